// ==== design/adc_ctrl_pkg.sv ====
package adc_ctrl_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 32;
   localparam logic [15:0] IDX_CONTROL = 16'hF060;
   localparam logic [15:0] IDX_START   = 16'hF061;
   localparam logic [15:0] IDX_RESULT  = 16'hF062;
   localparam logic [15:0] IDX_IRQSTAT = 16'hF064;
   localparam logic [15:0] IDX_IRQMASK = 16'hF065;
   localparam int CTRL_W = 8;
   localparam int MODE_BIT = 7;
   localparam int OVS_LO = 4;
   localparam int OVS_HI = 6;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int START_BIT = 0;
   localparam int ACTIVE_BIT = 1;
   localparam int END_BIT = 0;
   localparam int RES_W = 14;
   localparam int RES_LSB = 2;
   localparam int OVS_RATIO = 320;
   localparam int RES_SCALE = 51;
   localparam int DIV_MAX_LOG = 5;
   typedef enum logic {IDLE, CONVERT} conv_state_t;
endpackage : adc_ctrl_pkg

// ==== design/oversample_divider.sv ====
`timescale 1ns/1ps
module oversample_divider
   import adc_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Control
   input  wire logic       run,
   input  wire logic [2:0] sel,
   // Rate output
   output logic            sampleEn
);
   logic [DIV_MAX_LOG-1:0] count;
   logic [DIV_MAX_LOG-1:0] limit;
   wire logic [2:0] selClamp;
   wire logic       lastCycle;

   // Prohibited codes above the largest divide run at the slowest rate
   assign selClamp  = (sel > 3'(DIV_MAX_LOG)) ? 3'(DIV_MAX_LOG) : sel;
   assign limit     = DIV_MAX_LOG'((6'h01 << selClamp) - 6'h01);
   assign lastCycle = (count >= limit);
   assign sampleEn  = run && lastCycle;

   always_ff @(posedge clk) begin
      if (!reset_n || !run || lastCycle) begin
         count <= '0;
      end else begin
         count <= count + 1'b1;
      end
   end
endmodule : oversample_divider

// ==== design/decimation_counter.sv ====
`timescale 1ns/1ps
module decimation_counter
   import adc_ctrl_pkg::*;
#(
   parameter int RATIO = OVS_RATIO,
   parameter int SCALE = RES_SCALE
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // Control and modulator stream
   input  wire logic             clear,
   input  wire logic             sampleEn,
   input  wire logic             modBit,
   // Result
   output logic                  done,
   output logic [RES_W-1:0]      result
);
   localparam int CW = $clog2(RATIO + 1);
   logic [CW-1:0] samples;
   logic [CW-1:0] ones;
   wire logic     lastSample;
   wire logic [CW-1:0] onesNext;

   if (RATIO < 2 || RATIO * SCALE >= (1 << RES_W)) begin : g_check
      $error("decimation_counter: RATIO and SCALE overflow the result");
   end

   assign lastSample = sampleEn && (samples == CW'(RATIO - 1));
   assign onesNext   = ones + CW'(modBit);

   always_ff @(posedge clk) begin
      if (!reset_n || clear) begin
         samples <= '0;
         ones    <= '0;
         done    <= 1'b0;
         result  <= '0;
      end else begin
         done <= lastSample;
         if (sampleEn) begin
            samples <= lastSample ? '0 : samples + 1'b1;
            ones    <= lastSample ? '0 : onesNext;
         end
         if (lastSample) begin
            result <= RES_W'(onesNext * SCALE);
         end
      end
   end
endmodule : decimation_counter

// ==== design/delta_sigma_adc_control.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - A 14-bit result sits in bits 15..2 of the result register.
// - Software writes never change the result register.
// - Result read during a conversion is undefined; software must not use it.
// - Mode bit 7 resets to 0; 0 is wait mode, 1 continuous.
// - With mode bit 1 conversion runs whatever the start bit holds.
// - Oversample field bits 6..4 resets 000; 000..011 divide clock by 1,2,4,8.
// - Conversion end is visible by polling and through a wake-capable interrupt.
// - In wait mode writing start 1 gives exactly one conversion.
// - Conversion end sets the end flag; interrupt only if enabled.
// - Active flag is 1 through a wait conversion, then clears itself.
// - Continuous runs until mode cleared, reset or low-power entry.
module delta_sigma_adc_control
   import adc_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [DATA_W-1:0] writedata,
   output logic [DATA_W-1:0]      readdata,
   output logic                   waitrequest,
   // Modulator side
   input  wire logic              modBit,
   output logic                   sampleEn,
   output logic                   modRun,
   // System
   input  wire logic              lowPower,
   output logic                   irq
);
   logic [CTRL_W-1:0] control;
   logic [15:0]       resultReg;
   logic              irqStatus;
   logic              irqMask;
   logic              readValid;
   conv_state_t       state;
   conv_state_t       next_state;

   wire logic [15:0] index;
   wire logic        hitControl;
   wire logic        hitStart;
   wire logic        hitResult;
   wire logic        hitIrqStat;
   wire logic        hitIrqMask;
   wire logic        wrControl;
   wire logic        startWrite;
   wire logic        endClear;
   wire logic        wrMask;
   wire logic        modeOn;
   wire logic        modeDrop;
   wire logic        active;
   wire logic        convDone;
   wire logic        abortConv;
   wire logic        restartDec;
   wire logic [RES_W-1:0] decResult;
   wire logic [DATA_W-1:0] readMux;
   wire logic [2:0]  ovsSel;

   // Register decode: each printed offset is a word index
   assign index      = address[ADDR_W-1:2];
   assign hitControl = (index == IDX_CONTROL);
   assign hitStart   = (index == IDX_START);
   assign hitResult  = (index == IDX_RESULT);
   assign hitIrqStat = (index == IDX_IRQSTAT);
   assign hitIrqMask = (index == IDX_IRQMASK);
   assign wrControl  = write && hitControl;
   assign startWrite = write && hitStart && writedata[START_BIT];
   assign endClear   = write && hitIrqStat && writedata[END_BIT];
   assign wrMask     = write && hitIrqMask;

   assign modeOn   = control[MODE_BIT];
   assign modeDrop = wrControl && modeOn && !writedata[MODE_BIT];
   assign ovsSel   = control[OVS_HI:OVS_LO];
   assign active   = (state == CONVERT);
   assign modRun   = active;

   // Writes finish at once; reads take one extra cycle for registered data
   assign waitrequest = read && !readValid;

   assign readMux =
      hitControl ? DATA_W'(control) :
      hitStart   ? DATA_W'({active, 1'b0}) :
      hitResult  ? DATA_W'(resultReg) :
      hitIrqStat ? DATA_W'(irqStatus) :
      hitIrqMask ? DATA_W'(irqMask) :
      '0;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         readValid <= 1'b0;
         readdata  <= '0;
      end else begin
         readValid <= read && !readValid;
         if (read && !readValid) begin
            readdata <= readMux;
         end
      end
   end

   // Control register; start/status bits live in their own word
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         control <= CTRL_RESET;
      end else if (wrControl) begin
         control <= writedata[CTRL_W-1:0];
      end
   end

   // Low power or a dropped mode bit stops a running conversion at once
   assign abortConv  = lowPower || modeDrop;
   assign restartDec = !active || abortConv;

   always_comb begin
      next_state = state;
      case (state)
         IDLE: begin
            if (!lowPower && (modeOn || startWrite)) begin
               next_state = CONVERT;
            end
         end
         CONVERT: begin
            if (abortConv) begin
               next_state = IDLE;
            end else if (convDone && !modeOn) begin
               next_state = IDLE;
            end
         end
         default: next_state = IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state <= IDLE;
      end else begin
         state <= next_state;
      end
   end

   oversample_divider u_divider (
      .clk      (clk),
      .reset_n  (reset_n),
      .run      (active),
      .sel      (ovsSel),
      .sampleEn (sampleEn)
   );

   decimation_counter #(
      .RATIO (OVS_RATIO),
      .SCALE (RES_SCALE)
   ) u_decimator (
      .clk      (clk),
      .reset_n  (reset_n),
      .clear    (restartDec),
      .sampleEn (sampleEn),
      .modBit   (modBit),
      .done     (convDone),
      .result   (decResult)
   );

   // Only a finished conversion loads the result; bus writes are ignored
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         resultReg <= '0;
      end else if (convDone && active && !abortConv) begin
         resultReg <= {decResult, RES_LSB'(0)};
      end
   end

   // Sticky end flag: a new end wins over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irqStatus <= 1'b0;
         irqMask   <= 1'b0;
      end else begin
         irqStatus <= (irqStatus && !endClear) || (convDone && active);
         if (wrMask) begin
            irqMask <= writedata[END_BIT];
         end
      end
   end

   // Level request stays up in sleep so it can wake the processor
   assign irq = irqStatus && irqMask;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   a_result_low_zero: assert property (resultReg[RES_LSB-1:0] == '0)
      else $error("result low bits not zero");

   a_result_read_only: assert property (
      !(convDone && active) |=> $stable(resultReg))
      else $error("result changed without a conversion end");

   a_control_reset: assert property (
      $past(!reset_n) |-> control == CTRL_RESET)
      else $error("control not cleared by reset");

   a_cont_restart: assert property (
      convDone && active && modeOn && !abortConv
      |=> active ##1 (active || $past(abortConv)))
      else $error("continuous mode stopped after a result");

   // A wait conversion ends one cycle after its last sample, so the third cycle must be active
   a_div_by_two: assert property (
      (active && ovsSel == 3'h1 && sampleEn) ##1 (active && ovsSel == 3'h1)
      ##1 (active && ovsSel == 3'h1) |-> sampleEn && !$past(sampleEn))
      else $error("divide by two rate wrong");

   a_div_by_one: assert property (
      active && ovsSel == 3'h0 |-> sampleEn)
      else $error("undivided rate missing a pulse");

   a_end_sets_flag: assert property (
      convDone && active |=> irqStatus)
      else $error("end flag not set");

   a_irq_masked: assert property (
      !irqMask |-> !irq)
      else $error("interrupt raised while disabled");

   a_irq_wakes: assert property (
      convDone && active && irqMask && !wrMask |=> irq)
      else $error("no interrupt at conversion end");

   a_wait_once: assert property (
      convDone && active && !modeOn && !wrControl |=> !active)
      else $error("wait mode did not return to idle");

   a_start_begins: assert property (
      startWrite && !active && !lowPower |=> active)
      else $error("start write did not begin conversion");

   a_stop_on_drop: assert property (
      active && abortConv |=> !active)
      else $error("conversion not stopped");

   a_read_answer: assert property (
      read && waitrequest |=> !waitrequest)
      else $error("read answer late");

   c_wait_done: cover property (startWrite && !modeOn ##[1:1000] convDone);
   c_cont_two: cover property (modeOn && convDone ##[1:1000] convDone);
   c_irq_rise: cover property ($rose(irq));
endmodule : delta_sigma_adc_control

// ==== test/mod_stream_model.sv ====
`timescale 1ns/1ps
module mod_stream_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Converter side
   input  wire logic       sampleEn,
   input  wire logic       modRun,
   input  wire logic [2:0] duty,
   output logic            modBit
);
   logic [1:0] phase;
   logic       last;

   // Outside a conversion the stream toggles, so no stale bit can pass for data
   assign modBit = modRun ? ({1'b0, phase} < duty) : ~last;

   always_ff @(posedge clk) begin
      if (!reset_n || !modRun) begin
         phase <= 2'h0;
      end else if (sampleEn) begin
         phase <= phase + 2'h1;
      end
      last <= reset_n ? modBit : 1'b0;
   end
endmodule : mod_stream_model

// ==== test/delta_sigma_adc_control_tb_top.sv ====
`timescale 1ns/1ps
module delta_sigma_adc_control_tb_top;
   import adc_ctrl_pkg::*;
   localparam int LIMIT = 20000;
   logic              clk;
   logic              reset_n;
   logic [ADDR_W-1:0] address;
   logic              read;
   logic              write;
   logic [DATA_W-1:0] writedata;
   logic [DATA_W-1:0] readdata;
   logic              waitrequest;
   logic              modBit;
   logic              sampleEn;
   logic              modRun;
   logic              lowPower;
   logic              irq;
   logic [2:0]        duty;
   logic [DATA_W-1:0] rd;
   int                n_fail = 0;
   int                num_checks = 0;
   int                cyc = 0;
   int                pulses = 0;
   int                lastEn = 0;
   int                gap = 0;
   int                p0;

   delta_sigma_adc_control uut (.clk(clk), .reset_n(reset_n), .address(address),
      .read(read), .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .modBit(modBit), .sampleEn(sampleEn),
      .modRun(modRun), .lowPower(lowPower), .irq(irq));
   mod_stream_model model (.clk(clk), .reset_n(reset_n), .sampleEn(sampleEn),
      .modRun(modRun), .duty(duty), .modBit(modBit));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic checkPin(input string what, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask : checkPin

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish

   // Edge counter, pulse spacing monitor and hang limit
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (sampleEn === 1'b1) begin
         pulses <= pulses + 1;
         gap <= cyc - lastEn;
         lastEn <= cyc;
         if (modRun !== 1'b1) checkPin("sampleEn idle", 1'b0, 1'b1);
      end
      if (cyc == LIMIT) begin
         n_fail++;
         tally_and_finish();
      end
   end

   // A strobe is dropped with one idle edge after it, so calls never collide
   task automatic wr(input logic [15:0] idx, input logic [31:0] d);
      address <= {idx, 2'b00};
      writedata <= d;
      write <= 1'b1;
      do @(posedge clk); while (waitrequest !== 1'b0);
      write <= 1'b0;
      @(posedge clk);
   endtask : wr

   task automatic rd_reg(input logic [15:0] idx);
      address <= {idx, 2'b00};
      read <= 1'b1;
      do @(posedge clk); while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      @(posedge clk);
   endtask : rd_reg

   task automatic rchk(input logic [15:0] idx, input logic [31:0] exp, input string what);
      rd_reg(idx);
      check(what, exp, rd);
   endtask : rchk

   initial begin
      reset_n = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = '0;
      writedata = '0;
      lowPower = 1'b0;
      duty = 3'h0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      checkPin("irq", 1'b0, irq);
      rchk(IDX_CONTROL, 32'h0, "control");
      rchk(IDX_RESULT, 32'h0, "result");
      rchk(16'hF070, 32'h0, "unmapped");
      $display("test reset finished");
      for (int s = 0; s < 4; s++) begin
         duty <= 3'(s + 1);
         wr(IDX_CONTROL, 32'(s * 16 + 10));
         rchk(IDX_CONTROL, 32'(s * 16 + 10), "control");
         p0 = pulses;
         wr(IDX_START, 32'h1);
         rd_reg(IDX_START);
         checkPin("active", 1'b1, rd[ACTIVE_BIT]);
         wr(IDX_START, 32'h1);
         do rd_reg(IDX_START); while (rd[ACTIVE_BIT] !== 1'b0);
         // At full rate the divider also pulses in the closing cycle; that sample is dropped
         check("pulses", 32'(320 + (s == 0)), 32'(pulses - p0));
         check("gap", 32'(1 << s), 32'(gap));
         rchk(IDX_RESULT, 32'((s + 1) * 80 * 51 * 4), "result");
         rchk(IDX_IRQSTAT, 32'h1, "end flag");
         checkPin("irq", s > 0, irq);
         repeat (20) @(posedge clk);
         checkPin("modRun", 1'b0, modRun);
         wr(IDX_IRQMASK, 32'h1);
         checkPin("irq", 1'b1, irq);
         wr(IDX_IRQSTAT, 32'h1);
         rchk(IDX_IRQSTAT, 32'h0, "end flag");
         checkPin("irq", 1'b0, irq);
         $display("test wait mode select %0d finished", s);
      end
      // Software write must leave the last result in place
      wr(IDX_RESULT, 32'hFFFFFFFF);
      rchk(IDX_RESULT, 32'h0000FF00, "result");
      duty <= 3'h1;
      wr(IDX_CONTROL, 32'h80);
      do @(posedge clk); while (irq !== 1'b1);
      checkPin("modRun", 1'b1, modRun);
      rchk(IDX_RESULT, 32'h00003FC0, "result");
      wr(IDX_IRQSTAT, 32'h1);
      do @(posedge clk); while (irq !== 1'b1);
      wr(IDX_CONTROL, 32'h0);
      repeat (2) @(posedge clk);
      checkPin("modRun", 1'b0, modRun);
      wr(IDX_IRQSTAT, 32'h1);
      $display("test continuous finished");
      // Slowest select: one pulse every 32 clocks, two of them before the check
      wr(IDX_CONTROL, 32'hD0);
      repeat (70) @(posedge clk);
      check("gap", 32'd32, 32'(gap));
      checkPin("modRun", 1'b1, modRun);
      lowPower <= 1'b1;
      repeat (3) @(posedge clk);
      checkPin("modRun", 1'b0, modRun);
      wr(IDX_CONTROL, 32'h0);
      wr(IDX_START, 32'h1);
      repeat (5) @(posedge clk);
      checkPin("modRun", 1'b0, modRun);
      lowPower <= 1'b0;
      repeat (5) @(posedge clk);
      checkPin("modRun", 1'b0, modRun);
      $display("test low power finished");
      tally_and_finish();
   end
endmodule : delta_sigma_adc_control_tb_top
